// File: rtl/sfs_brake_heat.sv
// thermal model of the braking resistor: energy in while braking, coefficient out
`timescale 1ns/100ps
module sfs_brake_heat
  import sfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_us,
  input wire logic braking,
  input wire logic [15:0] brake_power,
  input wire logic [7:0] heat_coef,
  output logic overload
);
  typedef struct packed {
    logic [31:0] heat;
    logic ovl;
  } sfs_heat_t;
  sfs_heat_t q_reg, q_next;
  logic [31:0] gain;
  always_comb begin
    q_next = q_reg;
    gain = braking ? {16'h0, brake_power} : 32'h0;
    if (tick_us) begin
      // saturating on the way down keeps a cool resistor at zero
      if (q_reg.heat + gain > {24'h0, heat_coef}) begin
        q_next.heat = q_reg.heat + gain - {24'h0, heat_coef};
      end else begin
        q_next.heat = '0;
      end
      if (q_next.heat > SFS_HEAT_LIMIT) begin
        q_next.ovl = 1'b1;
        q_next.heat = SFS_HEAT_LIMIT;
      end else begin
        q_next.ovl = 1'b0;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
  assign overload = q_reg.ovl;
endmodule

// File: rtl/sfs_pkg.sv
// constants, register map and fault codes of the servo fault supervisor
package sfs_pkg;
  localparam int SFS_CLK_MHZ = 125;
  localparam logic [3:0] SFS_ADDR_STATUS = 4'h0;
  localparam logic [3:0] SFS_ADDR_MASK = 4'h1;
  localparam logic [3:0] SFS_ADDR_CODE = 4'h2;
  localparam logic [3:0] SFS_ADDR_SYNC_PER = 4'h3;
  localparam logic [3:0] SFS_ADDR_STALL_THR = 4'h4;
  localparam logic [3:0] SFS_ADDR_STALL_DUR = 4'h5;
  localparam logic [3:0] SFS_ADDR_BRAKE = 4'h6;
  localparam logic [3:0] SFS_ADDR_CTRL = 4'h7;
  localparam logic [3:0] SFS_ADDR_FAULTS = 4'h8;
  localparam int SFS_NF = 9;
  localparam int SFS_F_SYNC = 0;
  localparam int SFS_F_STALL = 1;
  localparam int SFS_F_BRAKE = 2;
  localparam int SFS_F_FWD = 3;
  localparam int SFS_F_REV = 4;
  localparam int SFS_F_ORIGIN = 5;
  localparam int SFS_F_BUSST = 6;
  localparam int SFS_F_MODE = 7;
  localparam int SFS_F_TURN = 8;
  localparam int SFS_F_BATT = 9;
  localparam int SFS_NFALL = 10;
  localparam logic [11:0] SFS_CODE_NONE = 12'h000;
  localparam logic [11:0] SFS_CODE_SYNC = 12'h217;
  localparam logic [11:0] SFS_CODE_STALL = 12'h219;
  localparam logic [11:0] SFS_CODE_BRAKE = 12'h220;
  localparam logic [11:0] SFS_CODE_FWD = 12'h221;
  localparam logic [11:0] SFS_CODE_REV = 12'h222;
  localparam logic [11:0] SFS_CODE_ORIGIN = 12'h223;
  localparam logic [11:0] SFS_CODE_BUSST = 12'h224;
  localparam logic [11:0] SFS_CODE_MODE = 12'h225;
  localparam logic [11:0] SFS_CODE_TURN = 12'h226;
  localparam logic [11:0] SFS_CODE_BATT = 12'h227;
  // one microsecond tick drives the sync and stall timers
  localparam logic [7:0] SFS_TICK_US_CYC = 8'(SFS_CLK_MHZ - 1);
  localparam logic [31:0] SFS_SYNC_PER_RST = 32'h0000_03E8;
  localparam logic [15:0] SFS_STALL_THR_RST = 16'h0064;
  localparam logic [31:0] SFS_STALL_DUR_RST = 32'h0000_C350;
  localparam logic [7:0] SFS_HEAT_COEF_RST = 8'h32;
  localparam logic [15:0] SFS_BRAKE_PWR_RST = 16'h0064;
  localparam logic [31:0] SFS_HEAT_LIMIT = 32'h00FF_FFFF;
  localparam logic [15:0] SFS_ZERO_SPEED = 16'h000A;
  localparam logic [7:0] SFS_MODES_OK = 8'h7F;
  localparam logic [7:0] SFS_DI_NONE = 8'h00;
  localparam logic [1:0] SFS_HM_NONE = 2'h0;
  localparam logic [1:0] SFS_HM_FWD = 2'h1;
  localparam logic [1:0] SFS_HM_REV = 2'h2;
  localparam logic [1:0] SFS_HM_BOTH = 2'h3;
endpackage

// File: rtl/sfs_supervisor.sv
// servo fault supervisor: fault detection, latching, code report and interrupt
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
// How it works
// R1 - sync timeout fault when no sync pulse arrives within the set period
// R2 - stall fault when current above threshold at near-zero speed for stall duration
// R3 - brake resistor overload when braking energy outruns modelled heat removal
// R4 - software sets heat coefficient, normally 50, and resistor values to match
// R5 - forward-limit-unassigned fault when homing needs it and no input mapped
// R6 - reverse-limit-unassigned fault when homing needs it and no input mapped
// R7 - origin-not-found fault when homing search ends without seeing origin switch
// R8 - bus state change to pre-operational during enabling raises bus-state fault
// R9 - unsupported operating mode requested by master raises mode fault
// R10 - multi-turn overflow in absolute mode raises turn-overflow fault
// R11 - battery-loss fault at first power-up after the encoder battery died
// R12 - battery fault clears on the next reset once the battery is back
// R13 - faults latch, code readable, cleared by reset unless another rule clears
module sfs_supervisor
  import sfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic sync_pulse,
  input wire logic sync_active,
  input wire logic [15:0] drive_current_percent,
  input wire logic [15:0] speed_abs,
  input wire logic braking,
  input wire logic [7:0] forward_limit_input_function,
  input wire logic [7:0] reverse_limit_input_function,
  input wire logic homing_start,
  input wire logic homing_search_done,
  input wire logic origin_switch,
  input wire logic drive_enabling,
  input wire logic bus_to_preop,
  input wire logic mode_req,
  input wire logic [2:0] mode_sel,
  input wire logic enc_absolute,
  input wire logic turn_overflow,
  input wire logic batt_lost,
  output logic [SFS_NFALL-1:0] fault_active,
  output logic irq
);
  typedef enum logic [2:0] {
    SFS_H_IDLE = 3'b001,
    SFS_H_SEARCH = 3'b010,
    SFS_H_FOUND = 3'b100
  } sfs_hstate_t;

  typedef struct packed {
    logic [7:0] tick_cnt;
    logic tick;
    sfs_hstate_t hstate;
    logic [SFS_NFALL-1:0] latch;
    logic [SFS_NFALL-1:0] status;
    logic [SFS_NFALL-1:0] mask;
    logic [31:0] sync_per;
    logic [15:0] stall_thr;
    logic [31:0] stall_dur;
    logic [15:0] brake_pwr;
    logic [7:0] heat_coef;
    logic [1:0] home_need;
    logic batt_seen;
    logic batt_caught;
    logic [31:0] rdata;
    logic irq;
  } sfs_state_t;

  sfs_state_t s_reg, s_next;
  logic sync_exp;
  logic stall_exp;
  logic brake_ovl;
  logic stall_cond;
  logic [SFS_NFALL-1:0] event_v;
  logic [11:0] code;

  assign stall_cond = (drive_current_percent > s_reg.stall_thr) &&
                      (speed_abs <= SFS_ZERO_SPEED); // [R2]

  // the timer restarts on each pulse, so only a missing pulse lets it expire
  sfs_timer u_sync_tmr (
    .clk(clk),
    .rst(rst),
    .tick_us(s_reg.tick),
    .run(sync_active && !sync_pulse), // [R1]
    .limit(s_reg.sync_per),
    .expired(sync_exp)
  );

  sfs_timer u_stall_tmr (
    .clk(clk),
    .rst(rst),
    .tick_us(s_reg.tick),
    .run(stall_cond), // [R2]
    .limit(s_reg.stall_dur),
    .expired(stall_exp)
  );

  sfs_brake_heat u_heat (
    .clk(clk),
    .rst(rst),
    .tick_us(s_reg.tick),
    .braking(braking),
    .brake_power(s_reg.brake_pwr), // [R4]
    .heat_coef(s_reg.heat_coef),
    .overload(brake_ovl)
  );

  always_comb begin
    event_v = '0;
    event_v[SFS_F_SYNC] = sync_exp; // [R1]
    event_v[SFS_F_STALL] = stall_exp; // [R2]
    event_v[SFS_F_BRAKE] = brake_ovl; // [R3]
    event_v[SFS_F_FWD] = homing_start && s_reg.home_need[0] &&
                         (forward_limit_input_function == SFS_DI_NONE); // [R5]
    event_v[SFS_F_REV] = homing_start && s_reg.home_need[1] &&
                         (reverse_limit_input_function == SFS_DI_NONE); // [R6]
    event_v[SFS_F_ORIGIN] = (s_reg.hstate == SFS_H_SEARCH) && homing_search_done &&
                            !origin_switch; // [R7]
    event_v[SFS_F_BUSST] = drive_enabling && bus_to_preop; // [R8]
    event_v[SFS_F_MODE] = mode_req && !SFS_MODES_OK[mode_sel]; // [R9]
    event_v[SFS_F_TURN] = enc_absolute && turn_overflow; // [R10]
    // battery loss is only reported from the value caught after reset
    event_v[SFS_F_BATT] = s_reg.batt_caught && s_reg.batt_seen; // [R11]
  end

  // lowest code wins when several faults stand
  always_comb begin
    code = SFS_CODE_NONE;
    if (s_reg.latch[SFS_F_SYNC]) begin
      code = SFS_CODE_SYNC;
    end else if (s_reg.latch[SFS_F_STALL]) begin
      code = SFS_CODE_STALL;
    end else if (s_reg.latch[SFS_F_BRAKE]) begin
      code = SFS_CODE_BRAKE;
    end else if (s_reg.latch[SFS_F_FWD]) begin
      code = SFS_CODE_FWD;
    end else if (s_reg.latch[SFS_F_REV]) begin
      code = SFS_CODE_REV;
    end else if (s_reg.latch[SFS_F_ORIGIN]) begin
      code = SFS_CODE_ORIGIN;
    end else if (s_reg.latch[SFS_F_BUSST]) begin
      code = SFS_CODE_BUSST;
    end else if (s_reg.latch[SFS_F_MODE]) begin
      code = SFS_CODE_MODE;
    end else if (s_reg.latch[SFS_F_TURN]) begin
      code = SFS_CODE_TURN;
    end else if (s_reg.latch[SFS_F_BATT]) begin
      code = SFS_CODE_BATT;
    end
  end

  always_comb begin
    s_next = s_reg;
    // microsecond tick
    if (s_reg.tick_cnt == SFS_TICK_US_CYC) begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 8'h1;
      s_next.tick = 1'b0;
    end
    // battery state is caught once, on the first cycle after reset release
    if (!s_reg.batt_caught) begin
      s_next.batt_caught = 1'b1;
      s_next.batt_seen = batt_lost; // [R12]
    end
    unique case (s_reg.hstate)
      SFS_H_IDLE: begin
        if (homing_start) begin
          s_next.hstate = SFS_H_SEARCH;
        end
      end
      SFS_H_SEARCH: begin
        if (origin_switch) begin
          s_next.hstate = SFS_H_FOUND;
        end else if (homing_search_done) begin
          s_next.hstate = SFS_H_IDLE; // [R7]
        end
      end
      SFS_H_FOUND: begin
        if (homing_search_done) begin
          s_next.hstate = SFS_H_IDLE;
        end
      end
      default: begin
        s_next.hstate = SFS_H_IDLE;
      end
    endcase
    s_next.latch = s_reg.latch | event_v; // [R13]
    s_next.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        SFS_ADDR_STATUS: s_next.rdata = 32'(s_reg.status);
        SFS_ADDR_MASK: s_next.rdata = 32'(s_reg.mask);
        SFS_ADDR_CODE: s_next.rdata = 32'(code); // [R13]
        SFS_ADDR_SYNC_PER: s_next.rdata = s_reg.sync_per;
        SFS_ADDR_STALL_THR: s_next.rdata = 32'(s_reg.stall_thr);
        SFS_ADDR_STALL_DUR: s_next.rdata = s_reg.stall_dur;
        SFS_ADDR_BRAKE: s_next.rdata = {8'h0, s_reg.heat_coef, s_reg.brake_pwr};
        SFS_ADDR_CTRL: s_next.rdata = 32'(s_reg.home_need);
        SFS_ADDR_FAULTS: s_next.rdata = 32'(s_reg.latch);
        default: s_next.rdata = '0;
      endcase
    end
    // status read clears; a new event in the same cycle survives
    if (rd_en && addr == SFS_ADDR_STATUS) begin
      s_next.status = event_v & ~s_reg.latch;
    end else begin
      s_next.status = s_reg.status | (event_v & ~s_reg.latch);
    end
    if (wr_en) begin
      unique case (addr)
        SFS_ADDR_MASK: s_next.mask = wdata[SFS_NFALL-1:0];
        SFS_ADDR_SYNC_PER: s_next.sync_per = wdata;
        SFS_ADDR_STALL_THR: s_next.stall_thr = wdata[15:0];
        SFS_ADDR_STALL_DUR: s_next.stall_dur = wdata;
        SFS_ADDR_BRAKE: begin
          s_next.brake_pwr = wdata[15:0];
          s_next.heat_coef = wdata[23:16]; // [R4]
        end
        SFS_ADDR_CTRL: s_next.home_need = wdata[1:0];
        default: begin
        end
      endcase
    end
    s_next.irq = |(s_next.status & s_next.mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.hstate <= SFS_H_IDLE;
      s_reg.sync_per <= SFS_SYNC_PER_RST;
      s_reg.stall_thr <= SFS_STALL_THR_RST;
      s_reg.stall_dur <= SFS_STALL_DUR_RST;
      s_reg.brake_pwr <= SFS_BRAKE_PWR_RST;
      s_reg.heat_coef <= SFS_HEAT_COEF_RST;
      s_reg.home_need <= SFS_HM_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign fault_active = s_reg.latch;
  assign irq = s_reg.irq;
endmodule

// File: rtl/sfs_timer.sv
// microsecond timer that flags once a running condition outlasts a limit
`timescale 1ns/100ps
module sfs_timer
  import sfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_us,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic exp;
  } sfs_tmr_t;
  sfs_tmr_t q_reg, q_next;
  always_comb begin
    q_next = q_reg;
    if (!run) begin
      q_next.cnt = '0;
      q_next.exp = 1'b0;
    end else if (tick_us && !q_reg.exp) begin
      q_next.cnt = q_reg.cnt + 32'h1;
      q_next.exp = (q_reg.cnt + 32'h1) >= limit;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
  assign expired = q_reg.exp;
endmodule

// File: testbench/sfs_assertions.sv
// port checker of the servo fault supervisor
`timescale 1ns/100ps
module sfs_checker
  import sfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic drive_enabling,
  input wire logic bus_to_preop,
  input wire logic mode_req,
  input wire logic [2:0] mode_sel,
  input wire logic enc_absolute,
  input wire logic turn_overflow,
  input wire logic batt_lost,
  input wire logic [SFS_NFALL-1:0] fault_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_bus; drive_enabling && bus_to_preop |=> fault_active[6]; endproperty
  a_bus: assert property (p_bus) else $error("bus fault");
  property p_busq; bus_to_preop && !drive_enabling && !fault_active[6] |=> !fault_active[6];
  endproperty
  a_busq: assert property (p_busq) else $error("bus fault early");
  property p_mode; mode_req && mode_sel == 3'h7 |=> fault_active[7]; endproperty
  a_mode: assert property (p_mode) else $error("mode fault");
  property p_modeq; mode_req && mode_sel != 3'h7 && !fault_active[7] |=> !fault_active[7];
  endproperty
  a_modeq: assert property (p_modeq) else $error("mode fault early");
  property p_turn; enc_absolute && turn_overflow |=> fault_active[8]; endproperty
  a_turn: assert property (p_turn) else $error("turn fault");
  property p_turnq; !enc_absolute && turn_overflow && !fault_active[8] |=> !fault_active[8];
  endproperty
  a_turnq: assert property (p_turnq) else $error("turn fault early");
  property p_batt; $past(rst) && batt_lost |-> ##[1:2] fault_active[9]; endproperty
  a_batt: assert property (p_batt) else $error("battery fault");
  property p_hold; ($past(fault_active) & ~fault_active) == '0; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  c_bus: cover property (drive_enabling && bus_to_preop);
  c_mode: cover property (mode_req && mode_sel == 3'h7);
  c_batt: cover property ($past(rst) && batt_lost);
endmodule
bind sfs_supervisor sfs_checker sfs_checker_inst (.clk(clk), .rst(rst),
  .drive_enabling(drive_enabling), .bus_to_preop(bus_to_preop), .mode_req(mode_req),
  .mode_sel(mode_sel), .enc_absolute(enc_absolute), .turn_overflow(turn_overflow),
  .batt_lost(batt_lost), .fault_active(fault_active));

// File: testbench/sfs_field.sv
// far-side model: fieldbus master sync source and bus state requests
`timescale 1ns/100ps
module sfs_field (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] gap,
  input wire logic preop_req,
  input wire logic rude,
  input wire logic drive_enabling,
  output logic sync_pulse,
  output logic bus_to_preop
);
  logic [15:0] cnt;
  // gap of 0 means the master has stopped sending sync
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0;
      sync_pulse <= 1'b0;
      bus_to_preop <= 1'b0;
    end else begin
      cnt <= (gap == 16'h0 || cnt + 16'h1 >= gap) ? 16'h0 : cnt + 16'h1;
      sync_pulse <= gap != 16'h0 && cnt + 16'h1 >= gap;
      // only a faulty master leaves operational mid-enable
      bus_to_preop <= preop_req && (rude || !drive_enabling);
    end
  end
endmodule

// File: testbench/tb.sv
// self-checking bench of the servo fault supervisor
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  import sfs_pkg::*;
  logic clk, rst, wr_en, rd_en, sync_pulse, sync_active, braking, homing_start;
  logic homing_search_done, origin_switch, drive_enabling, bus_to_preop, mode_req;
  logic enc_absolute, turn_overflow, batt_lost, irq, preop_req, rude;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] drive_current_percent, speed_abs, gap, rnd, thr;
  logic [7:0] forward_limit_input_function, reverse_limit_input_function;
  logic [2:0] mode_sel;
  logic [SFS_NFALL-1:0] fault_active;
  int miscompares, n_checks, mdl, st, msk;
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h3E8, 32'h64, 32'hC350, 32'h320064,
    32'h0, 32'h0, 32'h0};
  int codes [$] = '{SFS_CODE_SYNC, SFS_CODE_STALL, SFS_CODE_BRAKE, SFS_CODE_FWD, SFS_CODE_REV,
    SFS_CODE_ORIGIN, SFS_CODE_BUSST, SFS_CODE_MODE, SFS_CODE_TURN, SFS_CODE_BATT};
  sfs_supervisor sfs_supervisor_inst (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .sync_pulse, .sync_active, .drive_current_percent, .speed_abs, .braking,
    .forward_limit_input_function, .reverse_limit_input_function, .homing_start,
    .homing_search_done, .origin_switch, .drive_enabling, .bus_to_preop, .mode_req,
    .mode_sel, .enc_absolute, .turn_overflow, .batt_lost, .fault_active, .irq);
  sfs_field sfs_field_inst (.clk, .rst, .gap, .preop_req, .rude, .drive_enabling,
    .sync_pulse, .bus_to_preop);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // one idle edge keeps a following write from touching wr_en twice in one step
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // status bit only on the first latch of a fault
  task automatic ev(input int b);
    if (!mdl[b]) st |= 1 << b;
    mdl |= 1 << b;
  endtask
  task automatic chk();
    int c;
    c = 0;
    @(negedge clk);
    for (int i = 9; i >= 0; i--) if (mdl[i]) c = codes[i];
    `CHK("faults", 10'(mdl), fault_active)
    `CHK("irq", 1'((st & msk) != 0), irq)
    @(posedge clk);
    rd(SFS_ADDR_CODE, d);
    `CHK("code", 32'(c), d)
    rd(SFS_ADDR_FAULTS, d);
    `CHK("fault word", 32'(mdl), d)
    rd(SFS_ADDR_STATUS, d);
    `CHK("status", 32'(st), d)
    st = 0;
  endtask
  task automatic waitbit(input int b, input int lo, input int hi);
    int n;
    n = 0;
    // look at the latched output between edges, never in the edge that updates it
    @(negedge clk);
    while (fault_active[b] !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    `CHK("delay", 1'b1, 1'(n >= lo))
    if (n >= hi) begin
      miscompares++;
      end_of_test();
    end
    ev(b);
  endtask
  task automatic rst_seq(input logic b);
    batt_lost <= b;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    batt_lost <= 1'b0;
    mdl = b ? 'h200 : 0;
    st = mdl;
    msk = 0;
  endtask
  task automatic preop(input logic en, input logic bad);
    drive_enabling <= en;
    rude <= bad;
    preop_req <= 1'b1;
    @(posedge clk);
    preop_req <= 1'b0;
    repeat (3) @(posedge clk);
    drive_enabling <= 1'b0;
    @(posedge clk);
    if (en && bad) ev(6);
  endtask
  task automatic home(input logic org);
    homing_start <= 1'b1;
    @(posedge clk);
    homing_start <= 1'b0;
    origin_switch <= org;
    @(posedge clk);
    origin_switch <= 1'b0;
    homing_search_done <= 1'b1;
    @(posedge clk);
    homing_search_done <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {wr_en, rd_en, sync_active, braking, homing_start, homing_search_done} = '0;
    {origin_switch, drive_enabling, mode_req, enc_absolute, turn_overflow} = '0;
    {preop_req, rude, addr, wdata, mode_sel, gap, drive_current_percent, speed_abs} = '0;
    {forward_limit_input_function, reverse_limit_input_function} = '0;
    rnd = 16'h0A3A;
    rst = 1'b1;
    rst_seq(1'b1);
    chk();
    rst_seq(1'b0);
    chk();
    for (int a = 1; a < 10; a++) begin
      if (a != 2 && a != 8) begin
        rd(4'(a), d);
        `CHK("reset value", rv[a], d)
      end
    end
    preop(1'b1, 1'b0);
    preop(1'b0, 1'b0);
    preop(1'b1, 1'b1);
    chk();
    wr(SFS_ADDR_MASK, 32'h3FF);
    msk = 'h3FF;
    for (int m = 0; m < 10; m++) begin
      mode_sel <= 3'(m);
      enc_absolute <= 1'(m / 9);
      mode_req <= 1'(m < 8);
      turn_overflow <= 1'(m > 7);
      @(posedge clk);
      {mode_req, turn_overflow} <= 2'h0;
      @(posedge clk);
    end
    ev(7);
    ev(8);
    chk();
    wr(SFS_ADDR_CTRL, 32'h3);
    rnd = lfsr(rnd);
    reverse_limit_input_function <= rnd[7:0] | 8'h1;
    home(1'b1);
    ev(3);
    chk();
    forward_limit_input_function <= rnd[15:8] | 8'h1;
    reverse_limit_input_function <= 8'h0;
    home(1'b0);
    ev(4);
    ev(5);
    chk();
    rnd = lfsr(rnd);
    thr = {8'h0, rnd[7:0]} + 16'h10;
    wr(SFS_ADDR_STALL_THR, 32'(thr));
    wr(SFS_ADDR_STALL_DUR, 32'h5);
    speed_abs <= SFS_ZERO_SPEED;
    drive_current_percent <= thr;
    repeat (1500) @(posedge clk);
    speed_abs <= SFS_ZERO_SPEED + 16'h1;
    drive_current_percent <= thr + 16'h1;
    repeat (1500) @(posedge clk);
    chk();
    speed_abs <= SFS_ZERO_SPEED;
    waitbit(SFS_F_STALL, 500, 900);
    wr(SFS_ADDR_SYNC_PER, 32'h5);
    gap <= 16'h00FA;
    sync_active <= 1'b1;
    repeat (2000) @(posedge clk);
    chk();
    gap <= 16'h0;
    waitbit(SFS_F_SYNC, 240, 1200);
    wr(SFS_ADDR_BRAKE, 32'h0032_0010);
    braking <= 1'b1;
    repeat (2500) @(posedge clk);
    chk();
    wr(SFS_ADDR_BRAKE, 32'h0001_FFFF);
    waitbit(SFS_F_BRAKE, 31000, 40000);
    chk();
    end_of_test();
  end
endmodule
